/* i2cssf_addr_class.sv */
`timescale 1ns/1ps
module i2cssf_addr_class
   import i2cssf_pkg::*;
(
   input  wire logic [7:0]  addr_i,   // First byte after a start
   input  wire i2cssf_ids_t ids_i,    // Programmed IDs
   input  wire logic        gcen_i,   // General call enable
   output logic             match_o,  // Own ID matched
   output logic [1:0]       idx_o,    // Matching ID index
   output logic             gc_o,     // General call address
   output logic             spec_o    // High-speed code or start byte
);

   // ==========================================================
   // ID compare, lowest index wins
   always_comb begin
      match_o = 1'b0;
      idx_o   = 2'h0;
      for (int i = I2CSSF_ID_COUNT - 1; i >= 0; i--) begin
         if (ids_i.id[i][7:1] == addr_i[7:1]) begin
            match_o = 1'b1;
            idx_o   = 2'(i);
         end
      end
   end

   // Reserved codes
   assign gc_o   = gcen_i && (addr_i == I2CSSF_GC_ADDR);
   assign spec_o = (addr_i[7:3] == I2CSSF_HS_PREFIX) || (addr_i == I2CSSF_START_BYTE);

endmodule

/* i2cssf_master_model.sv */
`timescale 1ns/1ps
module i2cssf_master_model
   import i2cssf_pkg::*;
(
   input  wire logic clk_i,  // Bench clock
   output i2cssf_ev_t ev_o   // Bus events towards the slave
);
   // ==========================================================
   // Idle bus: no pulses, transmit data present
   initial begin
      ev_o = '0;
   end

   // ==========================================================
   // One-cycle start or stop condition
   task automatic cond(input logic is_stop);
      @(posedge clk_i);
      ev_o.start <= !is_stop;
      ev_o.stop  <= is_stop;
      @(posedge clk_i);
      ev_o.start <= 1'b0;
      ev_o.stop  <= 1'b0;
   endtask

   // ==========================================================
   // One received byte; data scrambled once released
   task automatic send(input logic [7:0] b, input logic tx);
      @(posedge clk_i);
      ev_o.byte_valid <= 1'b1;
      ev_o.data       <= b;
      ev_o.tx_empty   <= tx;
      @(posedge clk_i);
      ev_o.byte_valid <= 1'b0;
      ev_o.data       <= ~b;
   endtask
endmodule

/* i2cssf_pkg.sv */
package i2cssf_pkg;

   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] I2CSSF_OFS_STATUS = 8'h00;
   localparam logic [7:0] I2CSSF_OFS_CTRL   = 8'h04;

   // ==========================================================
   // Status field positions
   localparam int I2CSSF_ST_START_BIT = 14;
   localparam int I2CSSF_ST_REP_BIT   = 13;
   localparam int I2CSSF_ST_IDX_LSB   = 11;
   localparam int I2CSSF_ST_STOP_BIT  = 10;
   localparam int I2CSSF_ST_GENERAL_CALL_TYPE_LSB  = 8;
   localparam int I2CSSF_ST_GENERAL_CALL_IRQ_FLAG_BIT = 7;
   localparam int I2CSSF_ST_BUSY_BIT  = 6;
   localparam int I2CSSF_ST_NACK_BIT  = 5;

   // ==========================================================
   // Control field positions
   localparam int I2CSSF_CT_STOP_IEN_BIT = 8;
   localparam int I2CSSF_CT_FNACK_BIT    = 7;
   localparam int I2CSSF_CT_GCCLR_BIT    = 4;
   localparam int I2CSSF_CT_HGCEN_BIT    = 3;
   localparam int I2CSSF_CT_GCEN_BIT     = 2;

   // ==========================================================
   // Bus codes and general-call type codes
   localparam logic [7:0] I2CSSF_GC_ADDR     = 8'h00;
   localparam logic [7:0] I2CSSF_START_BYTE  = 8'h01;
   localparam logic [4:0] I2CSSF_HS_PREFIX   = 5'h01;
   localparam logic [7:0] I2CSSF_GC_RST_PROG = 8'h06;
   localparam logic [7:0] I2CSSF_GC_PROG     = 8'h04;
   localparam logic [1:0] I2CSSF_GENERAL_CALL_TYPE_NONE   = 2'h0;
   localparam logic [1:0] I2CSSF_GENERAL_CALL_TYPE_RST    = 2'h1;
   localparam logic [1:0] I2CSSF_GENERAL_CALL_TYPE_PROG   = 2'h2;
   localparam logic [1:0] I2CSSF_GENERAL_CALL_TYPE_HW     = 2'h3;
   localparam logic [1:0] I2CSSF_RESP_OKAY   = 2'h0;
   localparam logic [1:0] I2CSSF_RESP_SLVERR = 2'h2;
   localparam int         I2CSSF_ID_COUNT    = 4;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      I2CSSF_IDLE = 2'h0,
      I2CSSF_ADDR = 2'h1,
      I2CSSF_GC2  = 2'h2,
      I2CSSF_ACT  = 2'h3
   } i2cssf_state_t;

   typedef struct packed {
      logic [7:0] alt;
      logic [3:0][7:0] id;
   } i2cssf_ids_t;

   typedef struct packed {
      logic       start;
      logic       stop;
      logic       byte_valid;
      logic [7:0] data;
      logic       tx_empty;
   } i2cssf_ev_t;

   typedef struct packed {
      i2cssf_state_t st;
      logic          start_match;
      logic          rep;
      logic [1:0]    idx;
      logic          stop;
      logic [1:0]    general_call_type;
      logic          general_call_irq_flag;
      logic          busy;
      logic          nack;
      logic          stop_ien;
      logic          force_nack;
      logic          hgcen;
      logic          gcen;
      logic          bvalid;
      logic [1:0]    bresp;
      logic          rvalid;
      logic [1:0]    rresp;
      logic [31:0]   rdata;
      logic          nack_pulse;
      logic          rx_push;
      logic [7:0]    rx_byte;
      logic          gc_reset;
   } i2cssf_regs_t;

endpackage

/* i2cssf_top.sv */
// What this block does
// - Set start-match flag bit 14 on start with address matching a slave ID.
// - Also set it on enabled general call, high-speed code or start byte.
// - Clear start-match flag on any stop or start condition.
// - Set repeated-start flag bit 13 on start while start-match is set.
// - Repeated-start flag clears on status read or stop; not routed to the slave interrupt.
// - Matched-ID field bits 12:11 reports which of four IDs matched.
// - Set stop flag bit 10 on stop after a matching start.
// - Stop flag clears on status read.
// - With stop interrupt enabled, stop flag raises the slave interrupt.
// - General-call type bits 9:8: none, reset+program, program, hardware.
// - General-call type clears only by clear bit, not by general call reset.
// - Set general-call interrupt flag bit 7 on reset, program or hardware general call; always interrupts.
// - A general call reset returns control, repeated-start, stop, nack and matched-ID fields to defaults.
// - Hardware general call keeps its second byte in the receive FIFO.
// - Set slave-busy flag bit 6 on every start condition.
// - Busy clears on address miss, stop, or repeated-start address miss.
// - Set address-nacked flag bit 5 when own address was nacked.
// - Nack address on read with no data, or when forced-NACK bit set.
// - Address-nacked flag clears on status read.
// - Writing 1 to control bit 4 clears general-call status and type.
// - Control bit 8 enables the stop interrupt.
`timescale 1ns/1ps
module i2cssf_top
   import i2cssf_pkg::*;
#(
   parameter int ADDR_W = 8                       // AXI address width
)(
   input  wire logic              CLOCK_I,        // 50 MHz clock
   input  wire logic              RST_B_I,        // Async reset, low
   input  wire logic [ADDR_W-1:0] AXI_AWADDR_I,   // Write address
   input  wire logic              AXI_AWVALID_I,  // Write address valid
   output logic                   AXI_AWREADY_O,  // Write address ready
   input  wire logic [31:0]       AXI_WDATA_I,    // Write data
   input  wire logic [3:0]        AXI_WSTRB_I,    // Byte enables
   input  wire logic              AXI_WVALID_I,   // Write data valid
   output logic                   AXI_WREADY_O,   // Write data ready
   output logic [1:0]             AXI_BRESP_O,    // Write response
   output logic                   AXI_BVALID_O,   // Write response valid
   input  wire logic              AXI_BREADY_I,   // Write response ready
   input  wire logic [ADDR_W-1:0] AXI_ARADDR_I,   // Read address
   input  wire logic              AXI_ARVALID_I,  // Read address valid
   output logic                   AXI_ARREADY_O,  // Read address ready
   output logic [31:0]            AXI_RDATA_O,    // Read data
   output logic [1:0]             AXI_RRESP_O,    // Read response
   output logic                   AXI_RVALID_O,   // Read data valid
   input  wire logic              AXI_RREADY_I,   // Read data ready
   input  wire i2cssf_ev_t        BUS_EV_I,       // Bus events from slave engine
   input  wire i2cssf_ids_t       IDS_I,          // Programmed IDs and alt ID
   output logic                   SLAVE_IRQ_O,    // Slave interrupt request
   output logic                   ADDR_NACK_O,    // Pulse: nack this address
   output logic                   RX_PUSH_O,      // Pulse: push byte to rx FIFO
   output logic [7:0]             RX_BYTE_O,      // Byte for rx FIFO
   output logic                   GC_RESET_O      // Pulse: general call reset
);

   // ==========================================================
   // Parameter check: decode needs a full byte of address
   if (ADDR_W < 8) begin : g_bad_addr_w
      $error("ADDR_W must be at least 8");
   end

   // ==========================================================
   // Status word assembly
   function automatic logic [31:0] status_word(input i2cssf_regs_t s);
      logic [31:0] w;
      w = 32'h0;                                   // Bit 15 stays zero
      w[I2CSSF_ST_START_BIT]                    = s.start_match;
      w[I2CSSF_ST_REP_BIT]                      = s.rep;
      w[I2CSSF_ST_IDX_LSB +: 2]                 = s.idx;
      w[I2CSSF_ST_STOP_BIT]                     = s.stop;
      w[I2CSSF_ST_GENERAL_CALL_TYPE_LSB +: 2]                = s.general_call_type;
      w[I2CSSF_ST_GENERAL_CALL_IRQ_FLAG_BIT]                    = s.general_call_irq_flag;
      w[I2CSSF_ST_BUSY_BIT]                     = s.busy;
      w[I2CSSF_ST_NACK_BIT]                     = s.nack;
      return w;
   endfunction

   // Control word assembly
   function automatic logic [31:0] ctrl_word(input i2cssf_regs_t s);
      logic [31:0] w;
      w = 32'h0;
      w[I2CSSF_CT_STOP_IEN_BIT] = s.stop_ien;
      w[I2CSSF_CT_FNACK_BIT]    = s.force_nack;
      w[I2CSSF_CT_HGCEN_BIT]    = s.hgcen;
      w[I2CSSF_CT_GCEN_BIT]     = s.gcen;
      return w;
   endfunction

   // Register decode on the whole address, so aliases miss
   function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      return a == ADDR_W'(ofs);
   endfunction

   // ==========================================================
   // State and classifier
   i2cssf_regs_t r_r;
   i2cssf_regs_t r_nxt;
   logic         cls_match;
   logic [1:0]   cls_idx;
   logic         cls_gc;
   logic         cls_spec;

   i2cssf_addr_class u_class (
      .addr_i  (BUS_EV_I.data),
      .ids_i   (IDS_I),
      .gcen_i  (r_r.gcen),
      .match_o (cls_match),
      .idx_o   (cls_idx),
      .gc_o    (cls_gc),
      .spec_o  (cls_spec)
   );

   // ==========================================================
   // Bus handshakes
   logic wr_go;
   logic rd_go;
   logic wr_ctrl;
   logic rd_stat;
   logic gc_clr;

   assign wr_go         = AXI_AWVALID_I && AXI_WVALID_I && !r_r.bvalid;
   assign rd_go         = AXI_ARVALID_I && !r_r.rvalid;
   assign AXI_AWREADY_O = wr_go;
   assign AXI_WREADY_O  = wr_go;
   assign AXI_ARREADY_O = rd_go;
   assign wr_ctrl       = wr_go && reg_hit(AXI_AWADDR_I, I2CSSF_OFS_CTRL);
   assign rd_stat       = rd_go && reg_hit(AXI_ARADDR_I, I2CSSF_OFS_STATUS);
   assign gc_clr        = wr_ctrl && AXI_WSTRB_I[0] && AXI_WDATA_I[I2CSSF_CT_GCCLR_BIT];

   // ==========================================================
   // Next-state logic
   always_comb begin
      r_nxt            = r_r;
      r_nxt.nack_pulse = 1'b0;
      r_nxt.rx_push    = 1'b0;
      r_nxt.gc_reset   = 1'b0;

      // Read clears first, hardware sets below override
      if (rd_stat) begin
         r_nxt.rep  = 1'b0;
         r_nxt.stop = 1'b0;
         r_nxt.nack = 1'b0;
      end

      // Software clear of general-call status
      if (gc_clr) begin
         r_nxt.general_call_type  = I2CSSF_GENERAL_CALL_TYPE_NONE;
         r_nxt.general_call_irq_flag = 1'b0;
      end

      // Control writes, byte lanes honoured
      if (wr_ctrl) begin
         if (AXI_WSTRB_I[0]) begin
            r_nxt.force_nack = AXI_WDATA_I[I2CSSF_CT_FNACK_BIT];
            r_nxt.hgcen      = AXI_WDATA_I[I2CSSF_CT_HGCEN_BIT];
            r_nxt.gcen       = AXI_WDATA_I[I2CSSF_CT_GCEN_BIT];
         end
         if (AXI_WSTRB_I[1]) begin
            r_nxt.stop_ien = AXI_WDATA_I[I2CSSF_CT_STOP_IEN_BIT];
         end
      end

      // Bus events: stop, then start, then received byte
      if (BUS_EV_I.stop) begin
         if (r_r.start_match) begin
            r_nxt.stop = 1'b1;
         end
         r_nxt.start_match = 1'b0;
         r_nxt.rep         = 1'b0;
         r_nxt.busy        = 1'b0;
         r_nxt.st          = I2CSSF_IDLE;
      end else if (BUS_EV_I.start) begin
         if (r_r.start_match) begin
            r_nxt.rep = 1'b1;
         end
         r_nxt.start_match = 1'b0;
         r_nxt.busy        = 1'b1;
         r_nxt.st          = I2CSSF_ADDR;
      end else if (BUS_EV_I.byte_valid) begin
         case (r_r.st)
            I2CSSF_ADDR: begin
               if (cls_gc) begin
                  r_nxt.start_match = 1'b1;
                  r_nxt.st          = I2CSSF_GC2;
               end else if (cls_match) begin
                  r_nxt.start_match = 1'b1;
                  r_nxt.idx         = cls_idx;
                  r_nxt.st          = I2CSSF_ACT;
                  if (r_r.force_nack || (BUS_EV_I.data[0] && BUS_EV_I.tx_empty)) begin
                     r_nxt.nack       = 1'b1;
                     r_nxt.nack_pulse = 1'b1;
                  end
               end else if (cls_spec) begin
                  r_nxt.start_match = 1'b1;
                  r_nxt.st          = I2CSSF_IDLE;
               end else begin
                  r_nxt.busy = 1'b0;
                  r_nxt.st   = I2CSSF_IDLE;
               end
            end
            I2CSSF_GC2: begin
               r_nxt.st = I2CSSF_ACT;
               if (BUS_EV_I.data == I2CSSF_GC_RST_PROG) begin
                  // Defaults for control, rep, stop, nack and idx; start-match, busy and general-call status kept
                  r_nxt.stop_ien   = 1'b0;
                  r_nxt.force_nack = 1'b0;
                  r_nxt.hgcen      = 1'b0;
                  r_nxt.gcen       = 1'b0;
                  r_nxt.rep        = 1'b0;
                  r_nxt.stop       = 1'b0;
                  r_nxt.nack       = 1'b0;
                  r_nxt.idx        = 2'h0;
                  r_nxt.gc_reset   = 1'b1;
                  // Type is recorded here, never wiped by the reset
                  r_nxt.general_call_type       = I2CSSF_GENERAL_CALL_TYPE_RST;
                  r_nxt.general_call_irq_flag      = 1'b1;
               end else if (BUS_EV_I.data == I2CSSF_GC_PROG) begin
                  r_nxt.general_call_type  = I2CSSF_GENERAL_CALL_TYPE_PROG;
                  r_nxt.general_call_irq_flag = 1'b1;
               end else if (r_r.hgcen && (BUS_EV_I.data == IDS_I.alt)) begin
                  r_nxt.general_call_type    = I2CSSF_GENERAL_CALL_TYPE_HW;
                  r_nxt.general_call_irq_flag   = 1'b1;
                  r_nxt.rx_push = 1'b1;
                  r_nxt.rx_byte = BUS_EV_I.data;
               end
            end
            I2CSSF_ACT: begin
               r_nxt.st = I2CSSF_ACT;
            end
            default: begin
               r_nxt.st = I2CSSF_IDLE;
            end
         endcase
      end

      // Write response
      if (wr_go) begin
         r_nxt.bvalid = 1'b1;
         r_nxt.bresp  = (wr_ctrl || reg_hit(AXI_AWADDR_I, I2CSSF_OFS_STATUS)) ? I2CSSF_RESP_OKAY : I2CSSF_RESP_SLVERR;
      end else if (r_r.bvalid && AXI_BREADY_I) begin
         r_nxt.bvalid = 1'b0;
      end

      // Read response, data taken before the read clear
      if (rd_go) begin
         r_nxt.rvalid = 1'b1;
         r_nxt.rresp  = I2CSSF_RESP_OKAY;
         if (rd_stat) begin
            r_nxt.rdata = status_word(r_r);
         end else if (reg_hit(AXI_ARADDR_I, I2CSSF_OFS_CTRL)) begin
            r_nxt.rdata = ctrl_word(r_r);
         end else begin
            r_nxt.rdata = 32'h0;
            r_nxt.rresp = I2CSSF_RESP_SLVERR;
         end
      end else if (r_r.rvalid && AXI_RREADY_I) begin
         r_nxt.rvalid = 1'b0;
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign AXI_BVALID_O = r_r.bvalid;
   assign AXI_BRESP_O  = r_r.bresp;
   assign AXI_RVALID_O = r_r.rvalid;
   assign AXI_RRESP_O  = r_r.rresp;
   assign AXI_RDATA_O  = r_r.rdata;
   assign SLAVE_IRQ_O  = r_r.general_call_irq_flag || (r_r.stop && r_r.stop_ien);
   assign ADDR_NACK_O  = r_r.nack_pulse;
   assign RX_PUSH_O    = r_r.rx_push;
   assign RX_BYTE_O    = r_r.rx_byte;
   assign GC_RESET_O   = r_r.gc_reset;

   // ==========================================================
   // Checks
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (!RST_B_I);

   logic addr_byte;
   assign addr_byte = BUS_EV_I.byte_valid && !BUS_EV_I.start && !BUS_EV_I.stop && (r_r.st == I2CSSF_ADDR);

   sequence s_addr_hit;
      addr_byte && cls_match && !cls_gc;
   endsequence

   property p_start_set;
      s_addr_hit |=> r_r.start_match && (r_r.idx == $past(cls_idx));
   endproperty
   a_start_set: assert property (p_start_set) else $error("Start-match not set on match");

   property p_gc_set;
      addr_byte && cls_gc |=> r_r.start_match && (r_r.st == I2CSSF_GC2);
   endproperty
   a_gc_set: assert property (p_gc_set) else $error("Start-match not set on general call");

   property p_start_clr;
      (BUS_EV_I.start || BUS_EV_I.stop) |=> !r_r.start_match;
   endproperty
   a_start_clr: assert property (p_start_clr) else $error("Start-match not cleared");

   property p_rep;
      BUS_EV_I.start && !BUS_EV_I.stop && r_r.start_match |=> r_r.rep ##1 (r_r.rep || $past(rd_stat) || BUS_EV_I.stop || $past(BUS_EV_I.stop));
   endproperty
   a_rep: assert property (p_rep) else $error("Repeated start not flagged");

   property p_stop_irq;
      BUS_EV_I.stop && r_r.start_match && r_r.stop_ien && !wr_ctrl |=> r_r.stop ##0 SLAVE_IRQ_O;
   endproperty
   a_stop_irq: assert property (p_stop_irq) else $error("Stop interrupt missing");

   property p_gc_keep;
      (r_r.general_call_type != I2CSSF_GENERAL_CALL_TYPE_NONE) && !gc_clr |=> (r_r.general_call_type != I2CSSF_GENERAL_CALL_TYPE_NONE) && SLAVE_IRQ_O;
   endproperty
   a_gc_keep: assert property (p_gc_keep) else $error("General-call type lost");

   property p_busy;
      BUS_EV_I.start && !BUS_EV_I.stop |=> r_r.busy;
   endproperty
   a_busy: assert property (p_busy) else $error("Busy not set on start");

   property p_nack_win;
      (s_addr_hit and r_r.force_nack) |=> r_r.nack && ADDR_NACK_O;
   endproperty
   a_nack_win: assert property (p_nack_win) else $error("Forced nack not flagged");

   property p_bit15;
      r_r.rvalid |-> !AXI_RDATA_O[15];
   endproperty
   a_bit15: assert property (p_bit15) else $error("Reserved bit 15 set");

endmodule

/* test_i2c_slave_status_flags.sv */
`timescale 1ns/1ps
module test_i2c_slave_status_flags
   import i2cssf_pkg::*;
;
   typedef struct {
      logic [31:0] ctl;
      logic [7:0]  addr;
      logic        tx;
      logic [15:0] e1, m1, e2, m2;
      logic        irq;
   } i2cssf_row_t;

   logic        clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0]  awaddr, araddr, rx_last;
   logic [31:0] wdata, rdata, seen;
   logic        awready, wready, bvalid, arready, rvalid, irq, nack_p, push, gcr;
   logic [1:0]  bresp, rresp, resp;
   logic [7:0]  rx_byte;
   logic [3:0]  wstrb = 4'hf;
   i2cssf_ev_t  ev;
   i2cssf_ids_t ids;
   int          errors, samples_checked, nack_cnt, push_cnt, gcr_cnt;
   i2cssf_row_t rows[9];
   logic [7:0]  gc_b[3] = '{8'h06, 8'h04, 8'h9b};
   logic [31:0] gc_c[3] = '{32'h4, 32'h4, 32'hc};

   // ==========================================================
   // Clock, design and far-side model
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   i2cssf_top dut_u (.CLOCK_I(clk), .RST_B_I(rst_b), .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid),
      .AXI_AWREADY_O(awready), .AXI_WDATA_I(wdata), .AXI_WSTRB_I(wstrb), .AXI_WVALID_I(wvalid),
      .AXI_WREADY_O(wready), .AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready),
      .AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready), .AXI_RDATA_O(rdata),
      .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready), .BUS_EV_I(ev), .IDS_I(ids),
      .SLAVE_IRQ_O(irq), .ADDR_NACK_O(nack_p), .RX_PUSH_O(push), .RX_BYTE_O(rx_byte), .GC_RESET_O(gcr));

   i2cssf_master_model mdl (.clk_i(clk), .ev_o(ev));

   // Output pulse counters
   always @(posedge clk) begin
      if (nack_p === 1'b1) nack_cnt <= nack_cnt + 1;
      if (gcr === 1'b1) gcr_cnt <= gcr_cnt + 1;
      if (push === 1'b1) push_cnt <= push_cnt + 1;
      if (push === 1'b1) rx_last <= rx_byte;
   end

   // ==========================================================
   // Checking and bus tasks
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do @(posedge clk); while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      do @(posedge clk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Hang guard
   initial begin
      #400us;
      errors++;
      end_of_test();
   end

   // ==========================================================
   // Main sequence
   initial begin
      {rst_b, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
      ids = '{alt: 8'h9b, id: '{8'h50, 8'h40, 8'h30, 8'h20}};
      rows = '{
         '{32'h100, 8'h20, 1'b0, 16'h4040, 16'hffff, 16'h0400, 16'he7ff, 1'b1},
         '{32'h000, 8'h31, 1'b1, 16'h0020, 16'h0020, 16'h0000, 16'h8020, 1'b0},
         '{32'h000, 8'h41, 1'b0, 16'h5040, 16'hffff, 16'h0400, 16'he7ff, 1'b0},
         '{32'h100, 8'h50, 1'b1, 16'h5840, 16'hffff, 16'h0400, 16'he7ff, 1'b1},
         '{32'h100, 8'h62, 1'b0, 16'h0000, 16'he7ff, 16'h0000, 16'he7ff, 1'b0},
         '{32'h000, 8'h09, 1'b0, 16'h4000, 16'hc000, 16'h0000, 16'h8000, 1'b0},
         '{32'h000, 8'h01, 1'b0, 16'h4000, 16'hc000, 16'h0000, 16'h8000, 1'b0},
         '{32'h080, 8'h20, 1'b0, 16'h0020, 16'h0020, 16'h0000, 16'h8020, 1'b0},
         '{32'h000, 8'h00, 1'b0, 16'h0000, 16'h4380, 16'h0000, 16'h0380, 1'b0}};
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      // Reset values, read-only status, unmapped place
      rd(I2CSSF_OFS_STATUS, seen, resp);
      chk(seen & 32'hffff_ffe0, 32'h0);
      rd(I2CSSF_OFS_CTRL, seen, resp);
      chk(seen, 32'h0);
      wr(I2CSSF_OFS_STATUS, 32'hffff, resp);
      chk({30'h0, resp}, {30'h0, I2CSSF_RESP_OKAY});
      rd(I2CSSF_OFS_STATUS, seen, resp);
      chk(seen & 32'hffff_ffe0, 32'h0);
      wr(8'h08, 32'h1, resp);
      chk({30'h0, resp}, {30'h0, I2CSSF_RESP_SLVERR});
      rd(8'h08, seen, resp);
      chk({resp, seen[29:0]}, {I2CSSF_RESP_SLVERR, 30'h0});
      // Byte lanes: stop enable rides lane 1, the rest lane 0
      wstrb <= 4'h2;
      wr(I2CSSF_OFS_CTRL, 32'h184, resp);
      wstrb <= 4'h1;
      wr(I2CSSF_OFS_CTRL, 32'h004, resp);
      wstrb <= 4'hf;
      rd(I2CSSF_OFS_CTRL, seen, resp);
      chk(seen, 32'h104);
      $display("register access done");
      // Address table: flags after the address byte and after stop
      foreach (rows[i]) begin
         wr(I2CSSF_OFS_CTRL, rows[i].ctl, resp);
         mdl.cond(1'b0);
         mdl.send(rows[i].addr, rows[i].tx);
         rd(I2CSSF_OFS_STATUS, seen, resp);
         chk(seen & {16'hffff, rows[i].m1}, {16'h0, rows[i].e1});
         mdl.cond(1'b1);
         repeat (2) @(posedge clk);
         chk({31'h0, irq}, {31'h0, rows[i].irq});
         rd(I2CSSF_OFS_STATUS, seen, resp);
         chk(seen & {16'hffff, rows[i].m2}, {16'h0, rows[i].e2});
         $display("row %0d done", i);
      end
      chk(32'(nack_cnt), 32'd2);
      // Repeated start, read clear, stop clear
      wr(I2CSSF_OFS_CTRL, 32'h0, resp);
      mdl.cond(1'b0);
      mdl.send(8'h20, 1'b0);
      mdl.cond(1'b0);
      mdl.send(8'h20, 1'b0);
      rd(I2CSSF_OFS_STATUS, seen, resp);
      chk(seen, 32'h6040);
      rd(I2CSSF_OFS_STATUS, seen, resp);
      chk(seen, 32'h4040);
      mdl.cond(1'b0);
      mdl.send(8'h62, 1'b0);
      mdl.cond(1'b1);
      rd(I2CSSF_OFS_STATUS, seen, resp);
      chk(seen & 32'h6040, 32'h0);
      $display("repeated start done");
      // Stop lands in the cycle the status read clears
      mdl.cond(1'b0);
      mdl.send(8'h20, 1'b0);
      rd(I2CSSF_OFS_STATUS, seen, resp);
      fork
         mdl.cond(1'b1);
         rd(I2CSSF_OFS_STATUS, seen, resp);
      join
      rd(I2CSSF_OFS_STATUS, seen, resp);
      chk(seen & 32'h0400, 32'h0400);
      $display("set over clear done");
      // General call of each type, then software clear
      for (int k = 0; k < 3; k++) begin
         wr(I2CSSF_OFS_CTRL, gc_c[k], resp);
         mdl.cond(1'b0);
         mdl.send(I2CSSF_GC_ADDR, 1'b0);
         mdl.send(gc_b[k], 1'b0);
         mdl.cond(1'b1);
         rd(I2CSSF_OFS_STATUS, seen, resp);
         chk(seen & 32'h0380, (32'(k + 1) << 8) | 32'h80);
         chk({31'h0, irq}, 32'h1);
         if (k == 0) begin
            rd(I2CSSF_OFS_CTRL, seen, resp);
            chk(seen, 32'h0);
         end
         wr(I2CSSF_OFS_CTRL, 32'h10, resp);
         rd(I2CSSF_OFS_STATUS, seen, resp);
         chk(seen & 32'h0380, 32'h0);
         chk({31'h0, irq}, 32'h0);
      end
      chk(32'(gcr_cnt), 32'd1);
      chk(32'(push_cnt), 32'd1);
      chk({24'h0, rx_last}, 32'h9b);
      $display("general call done");
      // Reprogrammed IDs, two hits: lowest index reported
      ids <= '{alt: 8'h9b, id: '{8'h2a, 8'h40, 8'h2a, 8'h20}};
      mdl.cond(1'b0);
      mdl.send(8'h2b, 1'b0);
      rd(I2CSSF_OFS_STATUS, seen, resp);
      chk(seen, 32'h4840);
      // Reset in mid-transfer
      mdl.cond(1'b0);
      mdl.send(8'h20, 1'b0);
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rd(I2CSSF_OFS_STATUS, seen, resp);
      chk(seen & 32'hffff_ffe0, 32'h0);
      $display("mid-run reset done");
      end_of_test();
   end
endmodule
